// >>> sim/astx_remote.sv
/*
  Far-side serial device: decodes frames seen on the line, sends frames
  into the receive input. Assumes the block's core clock and bit time.
*/
`timescale 1ns/1ns
module astx_remote #(
  parameter int BIT_CLKS = 32
) (
  // Clock, line and decode bit count
  input  wire logic       core_clk,
  input  wire logic       line,
  input  wire logic [3:0] nbits,
  // Toward block
  output logic            rxd
);
  logic [8:0] got_q[$];
  logic [8:0] sh;
  initial rxd = 1'b1;
  // Frame decode from mid start bit
  always
  begin
    @(negedge line);
    repeat (BIT_CLKS / 2) @(posedge core_clk);
    if (line === 1'b0)
    begin
      sh = 9'h000;
      for (int i = 0; i < nbits; i++)
      begin
        repeat (BIT_CLKS) @(posedge core_clk);
        sh[i] = line;
      end
      repeat (BIT_CLKS) @(posedge core_clk);
      got_q.push_back(sh);
    end
  end
  // Start, eight data lsb first, stop; line high before
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    repeat (BIT_CLKS) @(posedge core_clk);
    for (int i = 0; i < 10; i++)
    begin
      @(posedge core_clk);
      rxd <= f[i];
      repeat (BIT_CLKS - 1) @(posedge core_clk);
    end
  endtask
endmodule

// >>> sim/astx_top_test.sv
/*
  Self-checking bench for the serial transmitter and status block.
  Assumes the block, its package and the far-side model are compiled.
*/
`timescale 1ns/1ns
module astx_top_test;
  localparam int BT = 32;
  localparam logic [1:0] A_BD = astx_pkg::ADDR_BAUD;
  localparam logic [1:0] A_CT = astx_pkg::ADDR_CTRL;
  localparam logic [1:0] A_ST = astx_pkg::ADDR_STATUS;
  localparam logic [1:0] A_DT = astx_pkg::ADDR_DATA;
  logic        core_clk;
  logic        nrst;
  logic [1:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic        reg_rd_long;
  logic [15:0] reg_rdata;
  logic        rxd;
  logic        txd_o;
  logic        txd_oe_n;
  logic        port_txd_val;
  logic        port_txd_dir;
  logic        irq_req;
  logic        line;
  logic [3:0]  nbits;
  int          errors = 0;
  int          checks = 0;
  // Pull-up on the line
  assign line = txd_oe_n ? 1'b1 : txd_o;

  astx_top dut_u (
    .core_clk     (core_clk),
    .nrst         (nrst),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rd_long  (reg_rd_long),
    .reg_rdata    (reg_rdata),
    .rxd          (rxd),
    .txd_o        (txd_o),
    .txd_oe_n     (txd_oe_n),
    .port_txd_val (port_txd_val),
    .port_txd_dir (port_txd_dir),
    .irq_req      (irq_req)
  );
  astx_remote #(.BIT_CLKS(BT)) far_u (
    .core_clk (core_clk),
    .line     (line),
    .nbits    (nbits),
    .rxd      (rxd)
  );

  task automatic wrap_up();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp);
  endtask
  task automatic bits(input int n);
    repeat (n * BT) @(posedge core_clk);
  endtask
  // Arm by status read, then load data
  task automatic load(input logic [15:0] d);
    logic [15:0] s;
    rd(A_ST, s);
    wr(A_DT, d);
  endtask

  task automatic t_reset();
    rd_chk(A_ST, 16'h0018);
    rd_chk(A_BD, 16'h0000);
    rd_chk(A_CT, 16'h0000);
    chk({15'h0000, line}, 16'h0001);
  endtask
  task automatic t_first();
    int n0;
    n0 = far_u.got_q.size();
    wr(A_BD, 16'h0001);
    wr(A_CT, 16'h0080);
    rd_chk(A_ST, 16'h0018);
    wr(A_DT, 16'h00a5);
    rd_chk(A_ST, 16'h0000);
    bits(26);
    chk(16'(far_u.got_q.size()), 16'(n0 + 1));
    chk({7'h00, far_u.got_q[$]}, 16'h00a5);
    rd_chk(A_ST, 16'h0018);
  endtask
  task automatic t_formats();
    logic [15:0] ct[6] = '{16'h0080, 16'h0090, 16'h00b0,
                           16'h00c0, 16'h00d0, 16'h00f0};
    logic [15:0] dt[6] = '{16'h003c, 16'h0013, 16'h0013,
                           16'h0155, 16'h0001, 16'h0001};
    logic [15:0] ex[6] = '{16'h003c, 16'h0093, 16'h0013,
                           16'h0155, 16'h0101, 16'h0001};
    for (int i = 0; i < 6; i++)
    begin
      wr(A_CT, ct[i]);
      nbits = (i < 3) ? 4'h8 : 4'h9;
      load(dt[i]);
      bits(16);
      chk({7'h00, far_u.got_q[$]}, ex[i]);
    end
    wr(A_CT, 16'h0080);
    nbits = 4'h8;
  endtask
  task automatic t_double();
    logic [15:0] s;
    int          n0;
    s = 16'h0000;
    load(16'h0011);
    for (int i = 0; i < 400 && s[4] !== 1'b1; i++)
      rd(A_ST, s);
    wr(A_DT, 16'h0022);
    bits(24);
    chk({7'h00, far_u.got_q[$ - 1]}, 16'h0011);
    chk({7'h00, far_u.got_q[$]}, 16'h0022);
    n0 = far_u.got_q.size();
    wr(A_DT, 16'h0033);
    bits(13);
    chk(16'(far_u.got_q.size()), 16'(n0));
    rd_chk(A_ST, 16'h0018);
  endtask
  task automatic t_rx();
    wr(A_CT, 16'h0480);
    rd_chk(A_ST, 16'h0018);
    far_u.send(8'h5a);
    bits(2);
    rd_chk(A_DT, 16'h005a);
    rd_chk(A_ST, 16'h001c);
    rd_chk(A_DT, 16'h005a);
    rd_chk(A_ST, 16'h0018);
    wr(A_CT, 16'h0484);
    far_u.send(8'hc3);
    bits(2);
    chk({15'h0000, irq_req}, 16'h0001);
    @(posedge core_clk);
    reg_rd_long <= 1'b1;
    reg_addr    <= A_ST;
    @(posedge core_clk);
    reg_rd_long <= 1'b0;
    @(negedge core_clk);
    chk({15'h0000, irq_req}, 16'h0000);
    rd_chk(A_ST, 16'h0018);
    wr(A_CT, 16'h0481);
    @(negedge core_clk);
    chk({15'h0000, irq_req}, 16'h0001);
  endtask
  task automatic t_break_off();
    wr(A_CT, 16'h0180);
    bits(3);
    chk({15'h0000, line}, 16'h0000);
    wr(A_CT, 16'h0080);
    bits(14);
    chk({15'h0000, line}, 16'h0001);
    rd_chk(A_ST, 16'h0018);
    wr(A_CT, 16'h0000);
    bits(12);
    @(posedge core_clk);
    port_txd_val <= 1'b0;
    @(negedge core_clk);
    chk({14'h0000, txd_oe_n, txd_o}, 16'h0000);
    wr(A_CT, 16'h0200);
    @(posedge core_clk);
    port_txd_val <= 1'b1;
    @(negedge core_clk);
    chk({15'h0000, txd_oe_n}, 16'h0001);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    wrap_up();
  end
  initial
  begin
    nrst         = 1'b0;
    reg_addr     = 2'h0;
    reg_wdata    = 16'h0000;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_rd_long  = 1'b0;
    port_txd_val = 1'b1;
    port_txd_dir = 1'b1;
    nbits        = 4'h8;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_first();
    t_formats();
    t_double();
    t_rx();
    t_break_off();
    wrap_up();
  end
endmodule

// >>> verilog/astx_pkg.sv
/*
  Constants and types for the async serial transmitter and status block.
  Assumes a 20 MHz core clock and a simple strobe register port.
*/
package astx_pkg;
  localparam logic [1:0] ADDR_BAUD   = 2'h0;
  localparam logic [1:0] ADDR_CTRL   = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_DATA   = 2'h3;
  localparam int CTL_TIE  = 0;
  localparam int CTL_TX_DONE_IRQ_EN = 1;
  localparam int CTL_RIE  = 2;
  localparam int CTL_IDLE_IRQ_EN = 3;
  localparam int CTL_PE   = 4;
  localparam int CTL_PT   = 5;
  localparam int CTL_M    = 6;
  localparam int CTL_TE   = 7;
  localparam int CTL_SBK  = 8;
  localparam int CTL_TX_OPEN_DRAIN_SEL = 9;
  localparam int CTL_RE   = 10;
  localparam int ST_PF    = 0;
  localparam int ST_IDLE  = 1;
  localparam int ST_RX_FULL_FLAG  = 2;
  localparam int ST_TC    = 3;
  localparam int ST_TX_HOLDING_EMPTY  = 4;
  localparam logic [15:0] RX_FLAG_MASK = 16'h0007;
  localparam logic [15:0] TX_FLAG_MASK = 16'h0018;
  localparam logic [12:0] BAUD_RST     = 13'h0000;
  localparam logic [10:0] CTRL_RST     = 11'h000;
  localparam logic [4:0]  PRESCALE_MAX = 5'h1f;
  localparam logic [3:0]  SAMPLES_BIT  = 4'hf;
  localparam logic [1:0]  START_ONES   = 2'h3;
  localparam logic [3:0]  FRAME10      = 4'ha;
  localparam logic [3:0]  FRAME11      = 4'hb;
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_DATA  = 4'b0010,
    TX_PRE   = 4'b0100,
    TX_BRK   = 4'b1000
  } astx_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE  = 3'b001,
    RX_SHIFT = 3'b010,
    RX_STOP  = 3'b100
  } astx_rx_st_t;
endpackage

// >>> verilog/astx_top.sv
/*
  Serial transmitter, simple receiver and status register block.
  Assumes a register master with one-cycle strobes, read data next cycle.
*/
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ns
module astx_top (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [1:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_rd_long,
  output logic      [15:0] reg_rdata,
  // Serial lines
  input  wire logic        rxd,
  output logic             txd_o,
  output logic             txd_oe_n,
  input  wire logic        port_txd_val,
  input  wire logic        port_txd_dir,
  // Requests
  output logic             irq_req
);
  typedef struct packed {
    logic              rst1;
    logic              rst2;
    logic [12:0]       baud_divisor;
    logic [10:0]       serial_ctrl_reg;
    logic [12:0]       baud_cnt;
    logic [4:0]        pre_cnt;
    logic              bit_tick;
    logic              samp_tick;
    logic [8:0]        tx_holding_reg;
    logic              tx_holding_empty;
    logic              tx_done_flag;
    logic              rx_full_flag;
    logic              idle_flag;
    logic              parity_err_flag;
    logic [15:0]       armed;
    astx_pkg::astx_tx_st_t tx_st;
    logic [10:0]       tx_shift;
    logic [3:0]        tx_bits;
    logic              tx_line;
    logic              te_prev;
    logic              pre_pend;
    logic              brk_mark;
    logic              tx_active;
    astx_pkg::astx_rx_st_t rx_st;
    logic [3:0]        rx_samp;
    logic [3:0]        rx_bits;
    logic [1:0]        rx_ones;
    logic [9:0]        rx_shift;
    logic [8:0]        rx_holding_reg;
    logic [15:0]       rdata;
  } astx_state_t;

  astx_state_t cur_ff;
  astx_state_t nxt_s;
  logic        rst_n;
  logic [15:0] status_word;
  logic [3:0]  frame_len;
  logic        te;
  logic        par_bit;
  logic [8:0]  tx_data;

  assign rst_n = cur_ff.rst2;
  assign te = cur_ff.serial_ctrl_reg[astx_pkg::CTL_TE];
  assign frame_len = cur_ff.serial_ctrl_reg[astx_pkg::CTL_M] ?
                     astx_pkg::FRAME11 : astx_pkg::FRAME10;

  always_comb
  begin
    status_word = 16'h0000;
    status_word[astx_pkg::ST_PF]   = cur_ff.parity_err_flag;
    status_word[astx_pkg::ST_IDLE] = cur_ff.idle_flag;
    status_word[astx_pkg::ST_RX_FULL_FLAG] = cur_ff.rx_full_flag;
    status_word[astx_pkg::ST_TC]   = cur_ff.tx_done_flag;
    status_word[astx_pkg::ST_TX_HOLDING_EMPTY] = cur_ff.tx_holding_empty;
  end

  always_comb
  begin
    logic data_rd;
    logic data_wr;
    logic st_rd;
    logic [15:0] clr;
    logic [15:0] set_ev;
    logic [8:0]  rx_word;
    logic        rx_par;
    data_rd = reg_rd && reg_addr == astx_pkg::ADDR_DATA;
    data_wr = reg_wr && reg_addr == astx_pkg::ADDR_DATA;
    st_rd   = reg_rd && reg_addr == astx_pkg::ADDR_STATUS;
    clr     = 16'h0000;
    set_ev  = 16'h0000;
    rx_word = 9'h000;
    rx_par  = 1'b0;
    nxt_s = cur_ff;
    nxt_s.rst1 = 1'b1;
    nxt_s.rst2 = cur_ff.rst1;
    nxt_s.rdata = 16'h0000;
    // Register writes
    if (reg_wr && reg_addr == astx_pkg::ADDR_BAUD)
      nxt_s.baud_divisor = reg_wdata[12:0];
    if (reg_wr && reg_addr == astx_pkg::ADDR_CTRL)
      nxt_s.serial_ctrl_reg = reg_wdata[10:0];
    if (data_wr)
      nxt_s.tx_holding_reg = reg_wdata[8:0];
    // Read data
    if (reg_rd)
    begin
      case (reg_addr)
        astx_pkg::ADDR_BAUD:   nxt_s.rdata = {3'h0, cur_ff.baud_divisor};
        astx_pkg::ADDR_CTRL:   nxt_s.rdata = {5'h00, cur_ff.serial_ctrl_reg};
        astx_pkg::ADDR_STATUS: nxt_s.rdata = status_word;
        astx_pkg::ADDR_DATA:   nxt_s.rdata = {7'h00, cur_ff.rx_holding_reg};
        default:               nxt_s.rdata = 16'h0000;
      endcase
    end
    // Clearing sequence
    if (st_rd)
      nxt_s.armed = status_word;
    if (reg_rd_long)
      clr = status_word & astx_pkg::RX_FLAG_MASK;
    else if (data_rd)
      clr = cur_ff.armed & astx_pkg::RX_FLAG_MASK;
    else if (data_wr)
      clr = cur_ff.armed;
    if (data_rd || data_wr || reg_rd_long)
      nxt_s.armed = 16'h0000;
    // Baud generator
    nxt_s.samp_tick = 1'b0;
    nxt_s.bit_tick = 1'b0;
    if (cur_ff.baud_divisor != 13'h0000)
    begin
      if (cur_ff.baud_cnt >= cur_ff.baud_divisor - 13'h0001)
      begin
        nxt_s.baud_cnt = 13'h0000;
        nxt_s.pre_cnt = cur_ff.pre_cnt + 5'h01;
        if (cur_ff.pre_cnt[0])
          nxt_s.samp_tick = 1'b1;
        if (cur_ff.pre_cnt == astx_pkg::PRESCALE_MAX)
          nxt_s.bit_tick = 1'b1;
      end
      else
        nxt_s.baud_cnt = cur_ff.baud_cnt + 13'h0001;
    end
    else
    begin
      nxt_s.baud_cnt = 13'h0000;
      nxt_s.pre_cnt = 5'h00;
    end
    // Transmitter
    nxt_s.te_prev = te;
    if (te && !cur_ff.te_prev)
      nxt_s.pre_pend = 1'b1;
    if (!te)
      nxt_s.tx_holding_empty = 1'b1;
    tx_data = cur_ff.tx_holding_reg;
    par_bit = cur_ff.serial_ctrl_reg[astx_pkg::CTL_PT];
    case ({cur_ff.serial_ctrl_reg[astx_pkg::CTL_M],
           cur_ff.serial_ctrl_reg[astx_pkg::CTL_PE]})
      2'b01: tx_data[7] = ^cur_ff.tx_holding_reg[6:0] ^ par_bit;
      2'b11: tx_data[8] = ^cur_ff.tx_holding_reg[7:0] ^ par_bit;
      default: tx_data = cur_ff.tx_holding_reg;
    endcase
    if (cur_ff.bit_tick)
    begin
      case (cur_ff.tx_st)
        astx_pkg::TX_IDLE:
        begin
          nxt_s.tx_line = 1'b1;
          nxt_s.tx_active = 1'b0;
          if (cur_ff.brk_mark)
            nxt_s.brk_mark = 1'b0;
          else if (cur_ff.pre_pend && te)
          begin
            nxt_s.pre_pend = 1'b0;
            nxt_s.tx_st = astx_pkg::TX_PRE;
          end
          else if (te && cur_ff.serial_ctrl_reg[astx_pkg::CTL_SBK])
          begin
            nxt_s.tx_st = astx_pkg::TX_BRK;
            nxt_s.tx_line = 1'b0;
          end
          else if (te && !cur_ff.tx_holding_empty)
          begin
            nxt_s.tx_st = astx_pkg::TX_DATA;
            nxt_s.tx_line = 1'b0;
            nxt_s.tx_shift = {1'b1, tx_data[8:0], 1'b0};
            if (!cur_ff.serial_ctrl_reg[astx_pkg::CTL_M])
              nxt_s.tx_shift = {2'b11, tx_data[7:0], 1'b0};
            set_ev[astx_pkg::ST_TX_HOLDING_EMPTY] = 1'b1;
          end
          if (nxt_s.tx_st != astx_pkg::TX_IDLE)
          begin
            nxt_s.tx_bits = frame_len - 4'h1;
            nxt_s.tx_active = 1'b1;
            nxt_s.tx_done_flag = 1'b0;
          end
        end
        astx_pkg::TX_DATA:
        begin
          nxt_s.tx_shift = {1'b1, cur_ff.tx_shift[10:1]};
          nxt_s.tx_line = cur_ff.tx_shift[1];
          nxt_s.tx_bits = cur_ff.tx_bits - 4'h1;
          if (cur_ff.tx_bits == 4'h0)
          begin
            nxt_s.tx_line = 1'b1;
            nxt_s.tx_st = astx_pkg::TX_IDLE;
            if (cur_ff.tx_holding_empty || !te)
              set_ev[astx_pkg::ST_TC] = 1'b1;
          end
        end
        astx_pkg::TX_PRE:
        begin
          nxt_s.tx_line = 1'b1;
          nxt_s.tx_bits = cur_ff.tx_bits - 4'h1;
          if (cur_ff.tx_bits == 4'h0)
          begin
            nxt_s.tx_st = astx_pkg::TX_IDLE;
            set_ev[astx_pkg::ST_TC] = 1'b1;
          end
        end
        astx_pkg::TX_BRK:
        begin
          nxt_s.tx_line = 1'b0;
          nxt_s.tx_bits = cur_ff.tx_bits - 4'h1;
          if (cur_ff.tx_bits == 4'h0)
          begin
            nxt_s.tx_bits = frame_len - 4'h1;
            if (!te || !cur_ff.serial_ctrl_reg[astx_pkg::CTL_SBK])
            begin
              nxt_s.tx_st = astx_pkg::TX_IDLE;
              nxt_s.tx_line = 1'b1;
              nxt_s.brk_mark = 1'b1;
              set_ev[astx_pkg::ST_TC] = 1'b1;
            end
          end
        end
        default: nxt_s.tx_st = astx_pkg::TX_IDLE;
      endcase
    end
    // Receiver, sampled on the sixteen-times tick
    if (cur_ff.samp_tick && cur_ff.serial_ctrl_reg[astx_pkg::CTL_RE])
    begin
      case (cur_ff.rx_st)
        astx_pkg::RX_IDLE:
        begin
          if (rxd && cur_ff.rx_ones != astx_pkg::START_ONES)
            nxt_s.rx_ones = cur_ff.rx_ones + 2'h1;
          if (!rxd && cur_ff.rx_ones == astx_pkg::START_ONES)
          begin
            nxt_s.rx_st = astx_pkg::RX_SHIFT;
            nxt_s.rx_samp = 4'h8;
            nxt_s.rx_bits = 4'h0;
          end
          else if (!rxd)
            nxt_s.rx_ones = 2'h0;
        end
        astx_pkg::RX_SHIFT:
        begin
          nxt_s.rx_samp = cur_ff.rx_samp + 4'h1;
          if (cur_ff.rx_samp == astx_pkg::SAMPLES_BIT)
          begin
            nxt_s.rx_shift = {rxd, cur_ff.rx_shift[9:1]};
            nxt_s.rx_bits = cur_ff.rx_bits + 4'h1;
            if (cur_ff.rx_bits == frame_len - 4'h2)
              nxt_s.rx_st = astx_pkg::RX_STOP;
          end
        end
        astx_pkg::RX_STOP:
        begin
          nxt_s.rx_st = astx_pkg::RX_IDLE;
          nxt_s.rx_ones = 2'h0;
          rx_word = cur_ff.serial_ctrl_reg[astx_pkg::CTL_M] ?
                    cur_ff.rx_shift[9:1] : {1'b0, cur_ff.rx_shift[9:2]};
          if (!cur_ff.rx_full_flag)
          begin
            nxt_s.rx_holding_reg = rx_word;
            set_ev[astx_pkg::ST_RX_FULL_FLAG] = 1'b1;
            rx_par = cur_ff.serial_ctrl_reg[astx_pkg::CTL_M] ?
                     ^rx_word[8:0] : ^rx_word[7:0];
            if (cur_ff.serial_ctrl_reg[astx_pkg::CTL_PE] &&
                (rx_par != cur_ff.serial_ctrl_reg[astx_pkg::CTL_PT]))
              set_ev[astx_pkg::ST_PF] = 1'b1;
          end
        end
        default: nxt_s.rx_st = astx_pkg::RX_IDLE;
      endcase
    end
    // Flag update, set wins over clear
    nxt_s.tx_holding_empty = (nxt_s.tx_holding_empty &
                              ~(data_wr & cur_ff.armed[astx_pkg::ST_TX_HOLDING_EMPTY]))
                             | set_ev[astx_pkg::ST_TX_HOLDING_EMPTY];
    nxt_s.tx_done_flag = (nxt_s.tx_done_flag & ~clr[astx_pkg::ST_TC])
                         | set_ev[astx_pkg::ST_TC];
    nxt_s.rx_full_flag = (cur_ff.rx_full_flag & ~clr[astx_pkg::ST_RX_FULL_FLAG])
                         | set_ev[astx_pkg::ST_RX_FULL_FLAG];
    nxt_s.parity_err_flag = (cur_ff.parity_err_flag & ~clr[astx_pkg::ST_PF])
                            | set_ev[astx_pkg::ST_PF];
    nxt_s.idle_flag = cur_ff.idle_flag & ~clr[astx_pkg::ST_IDLE];
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cur_ff <= '0;
      cur_ff.tx_holding_empty <= 1'b1;
      cur_ff.tx_done_flag <= 1'b1;
      cur_ff.tx_line <= 1'b1;
      cur_ff.tx_st <= astx_pkg::TX_IDLE;
      cur_ff.rx_st <= astx_pkg::RX_IDLE;
      cur_ff.baud_divisor <= astx_pkg::BAUD_RST;
      cur_ff.serial_ctrl_reg <= astx_pkg::CTRL_RST;
    end
    else if (!rst_n)
    begin
      cur_ff.rst1 <= 1'b1;
      cur_ff.rst2 <= cur_ff.rst1;
    end
    else
      cur_ff <= nxt_s;
  end

  // Pin drive: shifter owns pin while enabled or busy
  logic pin_val;
  logic pin_drv;
  always_comb
  begin
    if (te || cur_ff.tx_active || cur_ff.brk_mark)
    begin
      pin_val = cur_ff.tx_line;
      pin_drv = 1'b1;
    end
    else
    begin
      pin_val = port_txd_val;
      pin_drv = port_txd_dir;
    end
  end
  assign txd_o = pin_val;
  assign txd_oe_n = !(pin_drv &&
                     (!cur_ff.serial_ctrl_reg[astx_pkg::CTL_TX_OPEN_DRAIN_SEL] ||
                      !pin_val));
  assign reg_rdata = cur_ff.rdata;
  assign irq_req =
    (cur_ff.serial_ctrl_reg[astx_pkg::CTL_TIE] & cur_ff.tx_holding_empty) |
    (cur_ff.serial_ctrl_reg[astx_pkg::CTL_TX_DONE_IRQ_EN] & cur_ff.tx_done_flag) |
    (cur_ff.serial_ctrl_reg[astx_pkg::CTL_RIE] & cur_ff.rx_full_flag) |
    (cur_ff.serial_ctrl_reg[astx_pkg::CTL_IDLE_IRQ_EN] & cur_ff.idle_flag);

  // Checks
  property p_rdata_zero;
    @(posedge core_clk) disable iff (!rst_n)
    !$past(reg_rd) |-> reg_rdata == 16'h0000;
  endproperty
  a_rdata_zero: assert property (p_rdata_zero) else $error("rdata stale");
  property p_tc_busy;
    @(posedge core_clk) disable iff (!rst_n)
    (cur_ff.tx_st == astx_pkg::TX_DATA) |-> !cur_ff.tx_done_flag;
  endproperty
  a_tc_busy: assert property (p_tc_busy) else $error("tc set busy");
  property p_long_keeps_tx;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd_long && cur_ff.tx_done_flag && !cur_ff.bit_tick) |=>
      cur_ff.tx_done_flag;
  endproperty
  a_long_keeps_tx: assert property (p_long_keeps_tx)
    else $error("long read cleared tc");
  property p_brk_low;
    @(posedge core_clk) disable iff (!rst_n)
    (cur_ff.tx_st == astx_pkg::TX_BRK) |-> !cur_ff.tx_line;
  endproperty
  a_brk_low: assert property (p_brk_low) else $error("break high");
  property p_pre_high;
    @(posedge core_clk) disable iff (!rst_n)
    (cur_ff.tx_st == astx_pkg::TX_PRE) |-> cur_ff.tx_line;
  endproperty
  a_pre_high: assert property (p_pre_high) else $error("preamble low");
  property p_baud_stop;
    @(posedge core_clk) disable iff (!rst_n)
    (cur_ff.baud_divisor == 13'h0000) [*2] |-> !cur_ff.bit_tick;
  endproperty
  a_baud_stop: assert property (p_baud_stop) else $error("baud ran");
  property p_unarmed_keep;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == astx_pkg::ADDR_DATA && !cur_ff.armed[2] &&
     cur_ff.rx_full_flag) |=> cur_ff.rx_full_flag;
  endproperty
  a_unarmed_keep: assert property (p_unarmed_keep)
    else $error("unarmed clear");
  property p_arm;
    @(posedge core_clk) disable iff (!rst_n)
    (reg_rd && reg_addr == astx_pkg::ADDR_STATUS) |=>
      cur_ff.armed == $past(status_word);
  endproperty
  a_arm: assert property (p_arm) else $error("arm wrong");
  property p_irq;
    @(posedge core_clk) disable iff (!rst_n)
    (cur_ff.serial_ctrl_reg[3:0] == 4'h0) |-> !irq_req;
  endproperty
  a_irq: assert property (p_irq) else $error("irq ungated");
  c_brk: cover property (@(posedge core_clk) cur_ff.tx_st == astx_pkg::TX_BRK);
  c_pre: cover property (@(posedge core_clk) cur_ff.tx_st == astx_pkg::TX_PRE);
  c_rx: cover property (@(posedge core_clk) cur_ff.rx_full_flag);
endmodule
